/* File: core/ppfs_port_pin_function_select.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - The low two bits of a pin's output select field pick its driving output; bit 2 is ignored.
// - A hardware-controlled output overrides the software select field.
// - The debug reset input is sampled at power-on reset release; high enables on-chip debug.
// - Port 6 bit 3 offers port data, ccunit3 ch2, timer3 toggle, serial select; feeds two inputs.
// - Port 6 bit 2 offers port data, mux ctrl2, timer6 toggle, shift clock; feeds clock input.
// - Port 6 bit 1 offers port data, mux ctrl1, timer3 toggle, shift data; feeds four inputs.
// - Port 6 bit 0 offers port data, mux ctrl0, ccunit3 ch1, debug break; feeds two inputs.
// - Port 5 bits 0 and 1 are input only with readable value.
module ppfs_port_pin_function_select
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_on_reset_in,
  input wire logic debug_reset_in,
  input wire logic factory_test_enable,
  input wire logic [ppfs_pkg::SEL_W-1:0] port_io_control [ppfs_pkg::P6_PINS],
  input wire logic [ppfs_pkg::P6_PINS-1:0] port6_data_out,
  input wire ppfs_pkg::ppfs_periph_out_t periph_out,
  input wire ppfs_pkg::ppfs_hw_ctrl_t hardware_driven_output,
  input wire logic [ppfs_pkg::P6_PINS-1:0] port6_pad_in,
  output logic [ppfs_pkg::P6_PINS-1:0] port6_pad_out,
  output logic [ppfs_pkg::P6_PINS-1:0] port6_pad_oe,
  input wire logic [1:0] port5_pad_in,
  output logic [ppfs_pkg::P6_PINS-1:0] port6_in_value,
  output logic [1:0] port5_in_value,
  output ppfs_pkg::ppfs_periph_in_t periph_in,
  output logic onchip_debug_enable,
  output logic factory_test_active,
  output logic debug_reset_active
);

  logic [3:0] choice [ppfs_pkg::P6_PINS];
  logic [ppfs_pkg::P6_PINS-1:0] p6_lvl;
  logic p5s1_r [2];
  logic [1:0] p5s2_r;

  // Pin synchronisers; logic reads only the second stage
  logic por_s1_r;
  logic por_s2_r;
  logic por_d_r;
  logic por_rise;

  logic dbg_s1_r;
  logic dbg_s2_r;
  logic tst_s1_r;
  logic tst_s2_r;

  // Menu order is fixed: index 0 is always the port's own data
  // Shared by all four pins so the index order cannot drift
  function automatic logic [3:0] pin_menu
  (
    input var logic src3,
    input var logic src2,
    input var logic src1,
    input var logic port_bit
  );
    pin_menu = {src3, src2, src1, port_bit};
  endfunction

  // Per-pin output menus, index = low select bits
  always_comb
  begin
    choice[3] = pin_menu(periph_out.serial_select_out0, periph_out.timer3_toggle_out,
                         periph_out.ccunit3_ch2_out, port6_data_out[3]);
    choice[2] = pin_menu(periph_out.serial_shift_clock_out, periph_out.timer6_toggle_out,
                         periph_out.analog_mux_ctrl2, port6_data_out[2]);
    choice[1] = pin_menu(periph_out.serial_shift_data_out, periph_out.timer3_toggle_out,
                         periph_out.analog_mux_ctrl1, port6_data_out[1]);
    choice[0] = pin_menu(periph_out.debug_break_out, periph_out.ccunit3_ch1_out,
                         periph_out.analog_mux_ctrl0, port6_data_out[0]);
  end

  for (genvar i = 0; i < ppfs_pkg::P6_PINS; i++)
  begin : g_pin
    ppfs_pin_cell u_cell
    (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_output_select(port_io_control[i]),
      .out_choice(choice[i]),
      .hw_en(hardware_driven_output.hw_en[i]),
      .hw_val(hardware_driven_output.hw_val[i]),
      .pad_in(port6_pad_in[i]),
      .pad_out(port6_pad_out[i]),
      .pad_oe(port6_pad_oe[i]),
      .in_level(p6_lvl[i])
    );
  end

  // Readable level is the very sample the peripherals see
  assign port6_in_value = p6_lvl;

  // Input fan-out does not depend on select
  // Trap and triggers share one sample with the data input, no skew
  always_comb
  begin
    periph_in.serial_control_in_d = p6_lvl[3];
    periph_in.converter_trigger_f = p6_lvl[3];
    periph_in.serial_clock_in_c = p6_lvl[2];
    periph_in.converter_trigger_e = p6_lvl[1];
    periph_in.ccunit3_trap_in = p6_lvl[1];
    periph_in.serial_data_in_a = p6_lvl[1];
    periph_in.event_request1_in6 = p6_lvl[1];
    periph_in.converter_gate_g = p6_lvl[0];
    periph_in.serial_data_in_e = p6_lvl[0];
  end

  // Port 5: input only, no driver exists at all
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p5s1_r[0] <= 1'b0;
      p5s1_r[1] <= 1'b0;
    end
    else
    begin
      p5s1_r[0] <= port5_pad_in[0];
      p5s1_r[1] <= port5_pad_in[1];
    end
  end

  // Second stage is the readable value
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      p5s2_r <= 2'h0;
    else
      p5s2_r <= {p5s1_r[1], p5s1_r[0]};
  end

  assign port5_in_value = p5s2_r;

  // Power-on reset pin, two stages
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
    end
    else
    begin
      por_s1_r <= power_on_reset_in;
      por_s2_r <= por_s1_r;
    end
  end

  // One more stage gives the rising edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      por_d_r <= 1'b0;
    else
      por_d_r <= por_s2_r;
  end

  // Debug reset pin, two stages
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
    end
    else
    begin
      dbg_s1_r <= debug_reset_in;
      dbg_s2_r <= dbg_s1_r;
    end
  end

  assign por_rise = por_s2_r & ~por_d_r;

  // Strap caught on the reset's rising edge; sync delay matches on both paths
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      onchip_debug_enable <= 1'b0;
    end
    else if (por_rise)
    begin
      onchip_debug_enable <= dbg_s2_r;
    end
    else if (!por_s2_r)
    begin
      // Limitation: a short power-on dip drops debug until the next capture
      onchip_debug_enable <= 1'b0;
    end
  end

  // Debug system held in reset while input low; board must pulse it low once
  assign debug_reset_active = ~dbg_s2_r;

  // Test pin observed only; low means factory test, outside normal use
  // Reset high so factory test never looks active out of reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_s1_r <= 1'b1;
      tst_s2_r <= 1'b1;
    end
    else
    begin
      tst_s1_r <= factory_test_enable;
      tst_s2_r <= tst_s1_r;
    end
  end

  assign factory_test_active = ~tst_s2_r;

endmodule
`default_nettype wire

/* File: include/ppfs_pkg.sv */
package ppfs_pkg;

  // Output select field layout
  localparam int SEL_W = 4;
  localparam int SEL_EN_BIT = 3;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;

  // Output choices in the low two bits
  localparam logic [1:0] OUT_SEL0 = 2'h0;
  localparam logic [1:0] OUT_SEL1 = 2'h1;
  localparam logic [1:0] OUT_SEL2 = 2'h2;
  localparam logic [1:0] OUT_SEL3 = 2'h3;

  localparam int P6_PINS = 4;

  // Peripheral outputs offered to the port 6 pins
  typedef struct packed {
    logic ccunit3_ch2_out;
    logic ccunit3_ch1_out;
    logic timer3_toggle_out;
    logic timer6_toggle_out;
    logic analog_mux_ctrl0;
    logic analog_mux_ctrl1;
    logic analog_mux_ctrl2;
    logic debug_break_out;
    logic serial_select_out0;
    logic serial_shift_clock_out;
    logic serial_shift_data_out;
  } ppfs_periph_out_t;

  // Pin input functions delivered to peripherals
  typedef struct packed {
    logic serial_control_in_d;
    logic converter_trigger_f;
    logic serial_clock_in_c;
    logic converter_trigger_e;
    logic ccunit3_trap_in;
    logic serial_data_in_a;
    logic event_request1_in6;
    logic converter_gate_g;
    logic serial_data_in_e;
  } ppfs_periph_in_t;

  // Per-pin hardware takeover of the output
  typedef struct packed {
    logic [P6_PINS-1:0] hw_en;
    logic [P6_PINS-1:0] hw_val;
  } ppfs_hw_ctrl_t;

endpackage

/* File: core/ppfs_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_cell
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ppfs_pkg::SEL_W-1:0] pin_output_select,
  input wire logic [3:0] out_choice,
  input wire logic hw_en,
  input wire logic hw_val,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic in_level
);

  logic sync1_r;
  logic sync2_r;

  // Two stages before any reader sees the pad
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  assign in_level = sync2_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end
    else if (hw_en)
    begin
      pad_out <= hw_val;
      pad_oe <= 1'b1;
    end
    else
    begin
      // Bit 2 ignored: low two bits pick the source
      pad_out <= out_choice[pin_output_select[1:0]];
      pad_oe <= pin_output_select[ppfs_pkg::SEL_EN_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: verification/ppfs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfs_props
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_on_reset_in,
  input wire logic debug_reset_in,
  input wire logic [3:0] port_io_control [4],
  input wire ppfs_pkg::ppfs_hw_ctrl_t hardware_driven_output,
  input wire logic [3:0] port6_pad_in,
  input wire logic [3:0] port6_pad_out,
  input wire logic [3:0] port6_pad_oe,
  input wire logic [1:0] port5_pad_in,
  input wire logic [3:0] port6_in_value,
  input wire logic [1:0] port5_in_value,
  input wire ppfs_pkg::ppfs_periph_in_t periph_in,
  input wire logic onchip_debug_enable
);
  wire [3:0] en = hardware_driven_output.hw_en;
  wire [3:0] hv = hardware_driven_output.hw_val;
  wire [3:0] v = port6_in_value;
  wire [3:0] drv = {port_io_control[3][3], port_io_control[2][3],
    port_io_control[1][3], port_io_control[0][3]};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  oe_enable_a: assert property ($past(rst_n) |->
    port6_pad_oe == ($past(drv) | $past(en))) else $error("pad enable wrong");
  hw_override_a: assert property ($past(rst_n) |->
    ((port6_pad_out ^ $past(hv)) & $past(en)) == 4'h0) else $error("hw drive wrong");
  in6_sync_a: assert property ($past(rst_n, 2) && $past(rst_n) |->
    port6_in_value == $past(port6_pad_in, 2)) else $error("port6 level wrong");
  in5_sync_a: assert property ($past(rst_n, 2) && $past(rst_n) |->
    port5_in_value == $past(port5_pad_in, 2)) else $error("port5 level wrong");
  fanout_a: assert property (
    periph_in == {{2{v[3]}}, v[2], {4{v[1]}}, {2{v[0]}}}) else $error("fanout wrong");
  debug_on_a: assert property ((!power_on_reset_in && debug_reset_in)[*3] ##1
    (power_on_reset_in && debug_reset_in)[*3] |-> ##[0:3] onchip_debug_enable)
    else $error("debug not enabled");
  debug_off_a: assert property ((!power_on_reset_in)[*3] ##1
    (power_on_reset_in && !debug_reset_in)[*6] |-> !onchip_debug_enable)
    else $error("debug enabled");
  debug_hold_a: assert property (power_on_reset_in[*7] |->
    $stable(onchip_debug_enable)) else $error("debug enable moved");
endmodule
bind ppfs_port_pin_function_select ppfs_props ppfs_props_i (.*);
`default_nettype wire

/* File: verification/ppfs_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfs_board_model
(
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] ext_lvl,
  input wire logic dbg_strap,
  output logic [3:0] pad_lvl,
  output logic factory_test_enable,
  output logic debug_reset_in
);
  // Board drive is weak, so an enabled pad wins
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
  assign factory_test_enable = 1'b1;
  assign debug_reset_in = dbg_strap;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_reset_in = 1'b0;
  logic dbg_strap = 1'b0;
  logic debug_reset_in, factory_test_enable, onchip_debug_enable;
  logic factory_test_active, debug_reset_active;
  logic [3:0] port_io_control [4];
  logic [3:0] port6_data_out, port6_pad_in, port6_pad_out, port6_pad_oe, port6_in_value, ext;
  logic [1:0] port5_pad_in, port5_in_value;
  ppfs_pkg::ppfs_periph_out_t periph_out;
  ppfs_pkg::ppfs_periph_in_t periph_in;
  ppfs_pkg::ppfs_hw_ctrl_t hardware_driven_output;
  logic [5:0] lvl1 = 6'h00;
  logic [5:0] lvl2 = 6'h00;
  logic [7:0] want = 8'h00;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 6710;
  ppfs_port_pin_function_select ppfs_port_pin_function_select_i (.*);
  ppfs_board_model ppfs_board_model_i (.pad_out(port6_pad_out), .pad_oe(port6_pad_oe),
    .ext_lvl(ext), .dbg_strap, .pad_lvl(port6_pad_in), .factory_test_enable, .debug_reset_in);
  function automatic logic [1:0] want_pin(input int i);
    logic [3:0] s;
    ppfs_pkg::ppfs_periph_out_t p;
    p = periph_out;
    case (i)
      3: s = {p.serial_select_out0, p.timer3_toggle_out, p.ccunit3_ch2_out, 1'b0};
      2: s = {p.serial_shift_clock_out, p.timer6_toggle_out, p.analog_mux_ctrl2, 1'b0};
      1: s = {p.serial_shift_data_out, p.timer3_toggle_out, p.analog_mux_ctrl1, 1'b0};
      default: s = {p.debug_break_out, p.ccunit3_ch1_out, p.analog_mux_ctrl0, 1'b0};
    endcase
    s[0] = port6_data_out[i];
    if (hardware_driven_output.hw_en[i])
      return {1'b1, hardware_driven_output.hw_val[i]};
    return {port_io_control[i][3], s[port_io_control[i][1:0]]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    port_io_control = '{default: 4'h0};
    {port6_data_out, ext, port5_pad_in} = 10'h000;
    periph_out = '0;
    hardware_driven_output = '0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    // Strap high then low, each with its own power-on pulse
    for (int b = 1; b >= 0; b--)
    begin
      dbg_strap = b[0];
      repeat (4) @(negedge mclk);
      power_on_reset_in = 1'b1;
      repeat (6) @(negedge mclk);
      chk("debug reset", {7'h00, ~b[0]}, {7'h00, debug_reset_active});
      dbg_strap = 1'b0;
      repeat (4) @(negedge mclk);
      chk("debug enable", {7'h00, b[0]}, {7'h00, onchip_debug_enable});
      chk("debug reset low", 8'h01, {7'h00, debug_reset_active});
      power_on_reset_in = 1'b0;
      repeat (4) @(negedge mclk);
      chk("debug clear", 8'h00, {7'h00, onchip_debug_enable});
    end
    power_on_reset_in = 1'b1;
    for (int k = 0; k < 400; k++)
    begin
      @(negedge mclk);
      chk("pad drive", want, {port6_pad_oe, port6_pad_out});
      chk("pin level", {2'h0, lvl2}, {2'h0, port5_in_value, port6_in_value});
      chk("test active", 8'h00, {7'h00, factory_test_active});
      for (int i = 0; i < 4; i++)
        port_io_control[i] = 4'($random(seed));
      // Top source with the ignored bit set on every pin
      if (k % 37 == 0)
        port_io_control = '{default: 4'hF};
      {port6_data_out, ext, port5_pad_in} = 10'($random(seed));
      periph_out = 11'($random(seed));
      hardware_driven_output.hw_en = 4'($random(seed) & $random(seed));
      hardware_driven_output.hw_val = 4'($random(seed));
      for (int i = 0; i < 4; i++)
        {want[i + 4], want[i]} = want_pin(i);
      lvl2 = lvl1;
      #1;
      lvl1 = {port5_pad_in, port6_pad_in};
    end
    give_verdict();
  end
endmodule
`default_nettype wire
